/* verilog/art_regs.svh */
/*
 * register indices, field positions, reset values and constants of the
 * dual 8-bit auto-reload timer block.
 * assumes: included by bare name; byte address = 4 * index.
 */
`ifndef ART_REGS_SVH
`define ART_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ART_IDX_IRQ_REQ 7'h70
`define ART_IDX_IRQ_EN 7'h71
`define ART_IDX_IRQ_PRIO 7'h72
`define ART_IDX_T4_CTRL 7'h74
`define ART_IDX_T4_CNT 7'h75
`define ART_IDX_T4_RLD 7'h76
`define ART_IDX_T5_CTRL 7'h7a
`define ART_IDX_T5_CNT 7'h7b
`define ART_IDX_T5_RLD 7'h7c

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define ART_SEL_LSB 0
`define ART_SEL_MSB 2
`define ART_RUN_BIT 3
`define ART_OUT_BIT 7
`define ART_CTRL_ONES 8'h70
`define ART_T4_CTRL_RST 8'h70
`define ART_T5_CTRL_RST 8'h70

// ----------------------------------------------------------------------
// interrupt register fields
// ----------------------------------------------------------------------
`define ART_IRQ_T4_BIT 0
`define ART_IRQ_T5_BIT 1
`define ART_PRIO_T4_LSB 0
`define ART_PRIO_T5_LSB 2
`define ART_T4_VECTOR 16'h0036
`define ART_T5_VECTOR 16'h003a

// ----------------------------------------------------------------------
// prescaler divide shifts and bus answers
// ----------------------------------------------------------------------
`define ART_SH_DIV1 0
`define ART_SH_DIV2 1
`define ART_SH_DIV4 2
`define ART_SH_DIV8 3
`define ART_SH_DIV32 5
`define ART_SH_DIV256 8
`define ART_RESP_OKAY 2'h0
`define ART_RESP_SLVERR 2'h2

`endif

/* verilog/art_pkg.sv */
/*
 * types of the dual 8-bit auto-reload timer block.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package art_pkg;

    // register selected by a bus address
    typedef enum logic [3:0] {
        ART_REG_NONE,
        ART_REG_IRQ_REQ,
        ART_REG_IRQ_EN,
        ART_REG_IRQ_PRIO,
        ART_REG_T4_CTRL,
        ART_REG_T4_CNT,
        ART_REG_T4_RLD,
        ART_REG_T5_CTRL,
        ART_REG_T5_CNT,
        ART_REG_T5_RLD
    } art_reg_t;

    // count clock select field
    typedef enum logic [2:0] {
        ART_CLK_DIV1 = 3'h0,
        ART_CLK_DIV2 = 3'h1,
        ART_CLK_DIV4 = 3'h2,
        ART_CLK_DIV8 = 3'h3,
        ART_CLK_DIV32 = 3'h4,
        ART_CLK_DIV256 = 3'h5,
        ART_CLK_BAD6 = 3'h6,
        ART_CLK_BAD7 = 3'h7
    } art_clk_t;

endpackage

/* verilog/art_prescaler.sv */
/*
 * shared divider of the time-base tick into the six count rates.
 * assumes: tbc_tick is a one-cycle enable pulse on clk.
 */
`timescale 1ns/1ps
`include "art_regs.svh"

module art_prescaler (
    input wire logic clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic tbc_tick, // time-base enable pulse
    output logic [5:0] rate_tick // pulses at 1,1/2,1/4,1/8,1/32,1/256
);

    localparam int SH [6] = '{`ART_SH_DIV1, `ART_SH_DIV2, `ART_SH_DIV4,
                              `ART_SH_DIV8, `ART_SH_DIV32, `ART_SH_DIV256};

    logic [7:0] div_q;

    // free-running divide count, advanced on each time-base tick
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_q <= 8'h00;
        end else if (tbc_tick) begin
            div_q <= div_q + 8'h01;
        end
    end

    // one rate pulse when the low shift bits are all ones
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_rate
            if (SH[g] == 0) begin : g_full
                assign rate_tick[g] = tbc_tick;
            end else begin : g_div
                assign rate_tick[g] = tbc_tick & (&div_q[SH[g]-1:0]);
            end
        end
    endgenerate

endmodule

/* verilog/art_timer_core.sv */
/*
 * one 8-bit auto-reload up-counter with reload register and output level.
 * assumes: tick is a one-cycle enable; writes come from the bus slave.
 */
`timescale 1ns/1ps
`include "art_regs.svh"

module art_timer_core #(
    parameter int W = 8, // counter width
    parameter logic OUT_RST = 1'b0 // output level after reset
) (
    input wire logic clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic tick, // selected count clock pulse
    input wire logic run, // run bit
    input wire logic cnt_wr, // counter write strobe
    input wire logic rld_wr, // reload write strobe
    input wire logic [W-1:0] wdata, // write value
    input wire logic out_wr, // output level write strobe
    input wire logic out_wdata, // output level write value
    output logic [W-1:0] cnt_q, // counter
    output logic [W-1:0] rld_q, // reload register
    output logic out_q, // output level
    output logic ovf_hit, // overflow in this cycle
    output logic ovf_q // overflow pulse, one cycle after
);

    // overflow: all ones meets a count tick while running
    assign ovf_hit = run & tick & (&cnt_q);

    // counter: not reset; write wins over count, reload on overflow
    always_ff @(posedge clk) begin
        if (cnt_wr) begin
            cnt_q <= wdata;
        end else if (ovf_hit) begin
            cnt_q <= rld_q;
        end else if (run & tick) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // reload: also loaded by every counter write
    always_ff @(posedge clk) begin
        if (cnt_wr | rld_wr) begin
            rld_q <= wdata;
        end
    end

    // output level: software write sets it, overflow inverts it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_q <= OUT_RST;
        end else if (out_wr) begin
            out_q <= out_wdata;
        end else if (ovf_hit) begin
            out_q <= ~out_q;
        end
    end

    // registered overflow pulse for the baud clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_hit;
        end
    end

endmodule

/* verilog/art_top.sv */
/*
 * two 8-bit auto-reload timers (fourth and fifth) behind an AXI4-Lite
 * slave, with overflow request, enable and priority flags.
 * assumes: tbc_tick is a one-cycle time-base enable on clk; the
 * interrupt controller and serial channels sit outside.
 */
`timescale 1ns/1ps
`include "art_regs.svh"

module art_top
    import art_pkg::*;
#(
    parameter int ADDR_W = 12 // bus address width
) (
    input wire logic clk, // 125 MHz system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic tbc_tick, // time-base clock enable pulse
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic [2:0] s_axi_awprot, // write protection, unused
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic [2:0] s_axi_arprot, // read protection, unused
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic timer4_out_pin, // fourth timer output level to port
    output logic timer4_baud_tick, // fourth timer overflow pulse
    output logic timer5_baud_tick, // fifth timer overflow pulse
    output logic timer4_int_req, // fourth timer gated request
    output logic [1:0] timer4_int_prio, // fourth timer priority
    output logic [15:0] timer4_int_vector, // fourth timer vector
    output logic timer5_int_req, // fifth timer gated request
    output logic [1:0] timer5_int_prio, // fifth timer priority
    output logic [15:0] timer5_int_vector // fifth timer vector
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------

    // map a byte address onto a register
    function automatic art_reg_t reg_decode(input logic [ADDR_W-1:0] addr);
        logic [6:0] idx;
        idx = addr[8:2];
        reg_decode = ART_REG_NONE;
        if (addr[ADDR_W-1:9] == '0) begin
            case (idx)
                `ART_IDX_IRQ_REQ: reg_decode = ART_REG_IRQ_REQ;
                `ART_IDX_IRQ_EN: reg_decode = ART_REG_IRQ_EN;
                `ART_IDX_IRQ_PRIO: reg_decode = ART_REG_IRQ_PRIO;
                `ART_IDX_T4_CTRL: reg_decode = ART_REG_T4_CTRL;
                `ART_IDX_T4_CNT: reg_decode = ART_REG_T4_CNT;
                `ART_IDX_T4_RLD: reg_decode = ART_REG_T4_RLD;
                `ART_IDX_T5_CTRL: reg_decode = ART_REG_T5_CTRL;
                `ART_IDX_T5_CNT: reg_decode = ART_REG_T5_CNT;
                `ART_IDX_T5_RLD: reg_decode = ART_REG_T5_RLD;
                default: reg_decode = ART_REG_NONE;
            endcase
        end
    endfunction

    // pick the rate pulse named by a clock select field
    function automatic logic sel_tick(input logic [2:0] sel, input logic [5:0] rt);
        case (art_clk_t'(sel))
            ART_CLK_DIV1: sel_tick = rt[0];
            ART_CLK_DIV2: sel_tick = rt[1];
            ART_CLK_DIV4: sel_tick = rt[2];
            ART_CLK_DIV8: sel_tick = rt[3];
            ART_CLK_DIV32: sel_tick = rt[4];
            ART_CLK_DIV256: sel_tick = rt[5];
            default: sel_tick = 1'b0; // prohibited codes never count
        endcase
    endfunction

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------

    logic aw_full_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic w_full_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_hs;
    logic w_hs;
    logic do_write;
    logic aw_full_d;
    logic w_full_d;
    art_reg_t wsel;
    logic wen;

    assign aw_hs = s_axi_awvalid & awready_q;
    assign w_hs = s_axi_wvalid & wready_q;
    assign do_write = aw_full_q & w_full_q & ~bvalid_q;
    assign wsel = reg_decode(awaddr_q);
    assign wen = do_write & wstrb_q[0];

    // holding flags for address and data, taken in either order
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
        end
        if (aw_hs) begin
            aw_full_d = 1'b1;
        end
        if (w_hs) begin
            w_full_d = 1'b1;
        end
    end

    // address and data holding registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // write response, error for unmapped addresses
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `ART_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wsel == ART_REG_NONE) ? `ART_RESP_SLVERR : `ART_RESP_OKAY;
        end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // timers and control registers
    // ------------------------------------------------------------------

    logic [5:0] rate_tick;
    logic [2:0] t4_sel_q;
    logic t4_run_q;
    logic [2:0] t5_sel_q;
    logic t5_run_q;
    logic [7:0] t4_cnt;
    logic [7:0] t4_rld;
    logic t4_out;
    logic t4_hit;
    logic t4_ovf;
    logic [7:0] t5_cnt;
    logic [7:0] t5_rld;
    logic t5_out;
    logic t5_hit;
    logic t5_ovf;
    logic [7:0] wbyte;

    assign wbyte = wdata_q[7:0];

    art_prescaler u_presc (
        .clk(clk),
        .nrst(nrst),
        .tbc_tick(tbc_tick),
        .rate_tick(rate_tick)
    );

    // clock select and run bits; bits 6..4 are not stored
    always_ff @(posedge clk) begin
        if (!nrst) begin
            t4_sel_q <= 3'(`ART_T4_CTRL_RST & 8'h07);
            t4_run_q <= 1'b0;
            t5_sel_q <= 3'(`ART_T5_CTRL_RST & 8'h07);
            t5_run_q <= 1'b0;
        end else begin
            if (wen && wsel == ART_REG_T4_CTRL) begin
                t4_sel_q <= wbyte[`ART_SEL_MSB:`ART_SEL_LSB];
                t4_run_q <= wbyte[`ART_RUN_BIT];
            end
            if (wen && wsel == ART_REG_T5_CTRL) begin
                t5_sel_q <= wbyte[`ART_SEL_MSB:`ART_SEL_LSB];
                t5_run_q <= wbyte[`ART_RUN_BIT];
            end
        end
    end

    // fourth timer: output level writable through control bit 7
    art_timer_core #(
        .W(8),
        .OUT_RST(1'b0)
    ) u_t4 (
        .clk(clk),
        .nrst(nrst),
        .tick(sel_tick(t4_sel_q, rate_tick)),
        .run(t4_run_q),
        .cnt_wr(wen && wsel == ART_REG_T4_CNT),
        .rld_wr(wen && wsel == ART_REG_T4_RLD),
        .wdata(wbyte),
        .out_wr(wen && wsel == ART_REG_T4_CTRL),
        .out_wdata(wbyte[`ART_OUT_BIT]),
        .cnt_q(t4_cnt),
        .rld_q(t4_rld),
        .out_q(t4_out),
        .ovf_hit(t4_hit),
        .ovf_q(t4_ovf)
    );

    // fifth timer: upper nibble writes ignored, flag stays internal
    art_timer_core #(
        .W(8),
        .OUT_RST(1'b0)
    ) u_t5 (
        .clk(clk),
        .nrst(nrst),
        .tick(sel_tick(t5_sel_q, rate_tick)),
        .run(t5_run_q),
        .cnt_wr(wen && wsel == ART_REG_T5_CNT),
        .rld_wr(wen && wsel == ART_REG_T5_RLD),
        .wdata(wbyte),
        .out_wr(1'b0),
        .out_wdata(1'b0),
        .cnt_q(t5_cnt),
        .rld_q(t5_rld),
        .out_q(t5_out),
        .ovf_hit(t5_hit),
        .ovf_q(t5_ovf)
    );

    // ------------------------------------------------------------------
    // overflow request, enable and priority flags
    // ------------------------------------------------------------------

    logic [1:0] req_q;
    logic [1:0] en_q;
    logic [3:0] prio_q;
    logic [1:0] hit;

    assign hit = {t5_hit, t4_hit};

    // request flags: overflow sets, software writes zero to clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (hit[i]) begin
                    req_q[i] <= 1'b1;
                end else if (wen && wsel == ART_REG_IRQ_REQ) begin
                    req_q[i] <= wbyte[i];
                end
            end
        end
    end

    // enable and priority flags
    always_ff @(posedge clk) begin
        if (!nrst) begin
            en_q <= 2'h0;
            prio_q <= 4'h0;
        end else begin
            if (wen && wsel == ART_REG_IRQ_EN) begin
                en_q <= wbyte[1:0];
            end
            if (wen && wsel == ART_REG_IRQ_PRIO) begin
                prio_q <= wbyte[3:0];
            end
        end
    end

    // registered interrupt outputs to the controller
    always_ff @(posedge clk) begin
        if (!nrst) begin
            timer4_int_req <= 1'b0;
            timer5_int_req <= 1'b0;
            timer4_int_prio <= 2'h0;
            timer5_int_prio <= 2'h0;
            timer4_int_vector <= `ART_T4_VECTOR;
            timer5_int_vector <= `ART_T5_VECTOR;
        end else begin
            timer4_int_req <= req_q[`ART_IRQ_T4_BIT] & en_q[`ART_IRQ_T4_BIT];
            timer5_int_req <= req_q[`ART_IRQ_T5_BIT] & en_q[`ART_IRQ_T5_BIT];
            timer4_int_prio <= prio_q[`ART_PRIO_T4_LSB +: 2];
            timer5_int_prio <= prio_q[`ART_PRIO_T5_LSB +: 2];
            timer4_int_vector <= `ART_T4_VECTOR;
            timer5_int_vector <= `ART_T5_VECTOR;
        end
    end

    // pin level and baud pulses, all from flip-flops
    assign timer4_out_pin = t4_out;
    assign timer4_baud_tick = t4_ovf;
    assign timer5_baud_tick = t5_ovf;

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------

    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_hs;
    logic rvalid_d;
    logic [7:0] rd_byte;
    art_reg_t rsel;

    assign ar_hs = s_axi_arvalid & arready_q;
    assign rsel = reg_decode(s_axi_araddr);
    assign rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);

    // read value of the addressed register
    always_comb begin
        rd_byte = 8'h00;
        case (rsel)
            ART_REG_IRQ_REQ: rd_byte = {6'h00, req_q};
            ART_REG_IRQ_EN: rd_byte = {6'h00, en_q};
            ART_REG_IRQ_PRIO: rd_byte = {4'h0, prio_q};
            ART_REG_T4_CTRL: rd_byte = {t4_out, 3'h7, t4_run_q, t4_sel_q};
            ART_REG_T4_CNT: rd_byte = t4_cnt;
            ART_REG_T4_RLD: rd_byte = t4_rld;
            ART_REG_T5_CTRL: rd_byte = `ART_CTRL_ONES | {4'h0, t5_run_q, t5_sel_q};
            ART_REG_T5_CNT: rd_byte = t5_cnt;
            ART_REG_T5_RLD: rd_byte = t5_rld;
            default: rd_byte = 8'h00;
        endcase
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (!nrst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `ART_RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_hs) begin
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= (rsel == ART_REG_NONE) ? `ART_RESP_SLVERR : `ART_RESP_OKAY;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

/* testbench/art_top_sva.sv */
/* port checker of the dual auto-reload timer block.
   assumes: bound into art_top from the bench top file. */
`timescale 1ns/1ps
module art_top_sva #(
    parameter int ADDR_W = 12 // address width
) (
    input wire logic clk, // clock
    input wire logic nrst, // reset, active low
    input wire logic tbc_tick, // time-base pulse
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read addr valid
    input wire logic s_axi_arready, // read addr ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_bvalid, // response valid
    input wire logic s_axi_bready, // response ready
    input wire logic timer4_out_pin, // output level
    input wire logic timer4_baud_tick, // overflow pulse
    input wire logic timer5_baud_tick, // overflow pulse
    input wire logic [15:0] timer4_int_vector // vector
);
    // single clock domain
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_vec4; timer4_int_vector == 16'h0036; endproperty
    a_vec4: assert property (p_vec4) else $error("bad vector");
    property p_rdlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rdlat: assert property (p_rdlat) else $error("late read");
    property p_rdhold; s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved");
    property p_wrhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_wrhold: assert property (p_wrhold) else $error("response dropped");
    property p_t5ctl;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(12'h1e8)
        |=> s_axi_rdata[6:4] == 3'h7 && s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_t5ctl: assert property (p_t5ctl) else $error("control ones lost");
    property p_baud4; timer4_baud_tick |-> $past(tbc_tick); endproperty
    a_baud4: assert property (p_baud4) else $error("baud pulse without tick");
    property p_baud5; timer5_baud_tick |-> $past(tbc_tick); endproperty
    a_baud5: assert property (p_baud5) else $error("baud pulse without tick");
    property p_tog;
        $rose(timer4_baud_tick) |-> timer4_out_pin != $past(timer4_out_pin);
    endproperty
    a_tog: assert property (p_tog) else $error("no toggle");
    property p_pin;
        $changed(timer4_out_pin) |-> ##[0:1] (timer4_baud_tick || s_axi_bvalid);
    endproperty
    a_pin: assert property (p_pin) else $error("stray pin change");
endmodule

/* testbench/art_baud_model.sv */
/* serial channel stand-in: counts baud edges of each timer.
   assumes: baud ticks are one-cycle pulses on clk. */
`timescale 1ns/1ps
module art_baud_model (
    input wire logic clk, // clock
    input wire logic nrst, // reset, active low
    input wire logic tick4, // fourth timer baud
    input wire logic tick5, // fifth timer baud
    output int n4, // edges seen
    output int n5 // edges seen
);
    // each high cycle is one baud edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            n4 <= 0;
            n5 <= 0;
        end else begin
            n4 <= n4 + int'(tick4);
            n5 <= n5 + int'(tick5);
        end
    end
endmodule

/* testbench/art_top_tb_top.sv */
/* self-checking bench of the dual auto-reload timer block.
   assumes: design, checker and baud model compiled first. */
`timescale 1ns/1ps
module art_top_tb_top;
    logic clk = 1'b0, nrst = 1'b0, tbc_tick = 1'b0, o;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, timer4_int_prio, timer5_int_prio, r;
    logic timer4_out_pin, timer4_baud_tick, timer5_baud_tick, timer4_int_req, timer5_int_req;
    logic [15:0] timer4_int_vector, timer5_int_vector;
    logic [7:0] st, rl, v, c, m;
    logic [6:0] base;
    int failures = 0, n_compared = 0, ticks = 0, cyc = 0, n4, n5, t0, b0, nov, dv;
    art_top dut (.*);
    art_baud_model partner (.clk, .nrst, .tick4(timer4_baud_tick), .tick5(timer5_baud_tick),
        .n4, .n5);
    always #4 clk = ~clk;
    // count time-base ticks, cut a hang short
    always @(posedge clk) begin
        ticks <= ticks + int'(nrst && tbc_tick);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] i, input logic [7:0] x);
        @(posedge clk);
        s_axi_awaddr <= {3'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, x};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] i);
        @(posedge clk);
        s_axi_araddr <= {3'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // random time-base ticks, then let the pipeline settle
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge clk);
            tbc_tick <= 1'($urandom);
        end
        @(posedge clk);
        tbc_tick <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    function automatic int div(input int s);
        return s < 4 ? 1 << s : s == 4 ? 32 : s == 5 ? 256 : 0;
    endfunction
    // main sequence: clock codes 0 to 6 on both timers
    initial begin
        void'($urandom(32'h9414));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd(7'h74);
        chk(d, 32'h70);
        rd(7'h7a);
        chk(d, 32'h70);
        chk(timer4_int_vector, 32'h36);
        chk(timer5_int_vector, 32'h3a);
        wr(7'h7f, 8'h1);
        chk(r, 32'h2);
        rd(7'h7f);
        chk(r, 32'h2);
        chk(d, 32'h0);
        c = 8'($urandom);
        wr(7'h72, c);
        chk(r, 32'h0);
        wr(7'h71, 8'h1);
        chk({timer5_int_prio, timer4_int_prio}, c[3:0]);
        for (int k = 0; k < 2; k++) begin
            for (int s = 0; s < 7; s++) begin
                base = k ? 7'h7a : 7'h74;
                st = 8'($urandom);
                rl = 8'($urandom % 240);
                wr(base + 7'h1, st);
                rd(base + 7'h2);
                chk(d, st);
                wr(base + 7'h2, rl);
                rd(base + 7'h1);
                chk(d, st);
                o = 1'($urandom);
                c = {o, 3'($urandom), 1'b1, 3'(s)};
                wr(base, c);
                rd(base);
                m = k ? 8'h7f : 8'hff;
                chk(d & m, {o, 3'h7, 1'b1, 3'(s)} & m);
                if (k == 0) chk(timer4_out_pin, o);
                t0 = ticks;
                b0 = k ? n5 : n4;
                burst(600);
                dv = div(s);
                nov = 0;
                v = st;
                for (int t = t0 + 1; t <= ticks; t++) begin
                    if (dv != 0 && t % dv == 0) begin
                        nov += int'(v == 8'hff);
                        v = v == 8'hff ? rl : v + 8'h1;
                    end
                end
                rd(base + 7'h1);
                chk(d, v);
                chk((k ? n5 : n4) - b0, nov);
                rd(7'h70);
                chk(d[k], nov != 0);
                chk(timer4_out_pin, k ? 1'b0 : o ^ nov[0]);
                chk(k ? timer5_int_req : timer4_int_req, nov != 0 && k == 0);
                wr(7'h70, 8'h0);
                wr(base, 8'h0);
                burst(40);
                rd(base + 7'h1);
                chk(d, v);
            end
        end
        complete_run();
    end
endmodule
bind art_top art_top_sva #(.ADDR_W(ADDR_W)) sva_i (.*);
